/* File: design/flash_boot_pkg.sv */
// Shared constants, types and register map for the flash overlay and boot control block
`default_nettype none

package flash_boot_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0]  OVL_CTRL_OFFSET    = 4'h0;
  localparam logic [3:0]  BOOT_STATUS_OFFSET = 4'h1;
  localparam logic [3:0]  BIT_PERIOD_OFFSET  = 4'h2;
  localparam logic [15:0] OVL_CTRL_RESET     = 16'h0000;
  localparam logic [15:0] OVL_CTRL_RW_MASK   = 16'h0007;
  localparam int          EMU_SEL_BIT        = 2;
  localparam int          AREA_HI_BIT        = 1;
  localparam int          AREA_LO_BIT        = 0;

  // ----------------------------------------------------------------
  // Address map of the overlay
  // ----------------------------------------------------------------
  localparam logic [23:0] FLASH_OVL_BASE = 24'h01f000;
  localparam logic [23:0] OVL_RAM_BASE   = 24'hffe800;
  localparam logic [23:0] TRANSFER_BASE  = 24'hfff000;
  localparam int          OVL_BLOCK_BITS = 10;

  // ----------------------------------------------------------------
  // Mode pin encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] PLL_X1      = 2'h0;
  localparam logic [1:0] PLL_X2      = 2'h1;
  localparam logic [1:0] PLL_X4      = 2'h2;
  localparam logic [1:0] PLL_INVALID = 2'h3;

  // ----------------------------------------------------------------
  // Serial boot link
  // ----------------------------------------------------------------
  localparam logic [7:0] ADJUST_END_BYTE = 8'h00;
  localparam logic [7:0] SYNC_BYTE       = 8'h00;
  localparam logic [7:0] ACK_BYTE        = 8'h55;
  localparam int         DATA_BITS       = 8;
  localparam logic [3:0] FRAME_LAST      = 4'h9;
  localparam int         MEAS_W          = 19;
  localparam logic [5:0] DIV9_MUL        = 6'h39;
  localparam int         DIV9_SHIFT      = 9;

  typedef enum logic [3:0] {
    ST_OFF, ST_WAIT_IDLE, ST_MEASURE, ST_SEND_END, ST_WAIT_TX, ST_WAIT_ACK,
    ST_LEN_HI, ST_LEN_LO, ST_LOAD, ST_BRANCH, ST_RUN, ST_FAIL
  } boot_state_e;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

  typedef struct packed {
    logic        valid;
    logic [23:0] addr;
    logic [7:0]  data;
  } ram_wr_s;

  typedef struct packed {
    logic [6:0] zero;
    logic       flash_pe_allowed;
    logic       link_error;
    logic       load_done;
    logic       adjust_done;
    logic [1:0] pll_mult;
    logic       single_chip;
    logic       boot_mode;
    logic       onboard;
  } boot_status_s;

endpackage : flash_boot_pkg

`default_nettype wire

/* File: design/serial_link.sv */
// Asynchronous 8N1 serial transmitter and receiver with a programmable bit period
`default_nettype none

module serial_link (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        enable,
  input  wire logic [15:0] bit_period,
  input  wire logic        rx_pin,
  input  wire logic        tx_start,
  input  wire logic [7:0]  tx_data,
  output var  logic        tx_pin,
  output var  logic        tx_busy,
  output var  logic        rx_valid,
  output var  logic [7:0]  rx_data,
  output var  logic        rx_error
);
  import flash_boot_pkg::*;

  logic        rx_prev;
  logic        rx_active;
  logic [15:0] rx_cnt;
  logic [3:0]  rx_idx;
  logic [15:0] tx_cnt;
  logic [3:0]  tx_idx;
  logic [9:0]  tx_shift;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire rx_fall    = enable & rx_prev & ~rx_pin & ~rx_active;
  wire rx_tick    = rx_active & (rx_cnt == 16'h0000);
  wire rx_is_stop = rx_idx == FRAME_LAST;
  wire tx_tick    = tx_busy & (tx_cnt == 16'h0000);
  wire tx_is_last = tx_idx == FRAME_LAST;

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  // Sampling at mid-bit tolerates the residual rate error of the measured period
  // 8 data, 1 stop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_prev   <= 1'b1;
      rx_active <= 1'b0;
      rx_cnt    <= 16'h0000;
      rx_idx    <= 4'h0;
      rx_data   <= 8'h00;
      rx_valid  <= 1'b0;
      rx_error  <= 1'b0;
    end else begin
      rx_prev  <= rx_pin;
      rx_valid <= 1'b0;
      rx_error <= 1'b0;
      if (rx_fall) begin
        rx_active <= 1'b1;
        rx_cnt    <= {1'b0, bit_period[15:1]};
        rx_idx    <= 4'h0;
      end else if (rx_tick) begin
        rx_cnt <= bit_period - 16'h0001;
        rx_idx <= rx_idx + 4'h1;
        if (rx_idx == 4'h0 && rx_pin) begin
          rx_active <= 1'b0;
        end else if (rx_is_stop) begin
          rx_active <= 1'b0;
          rx_valid  <= rx_pin;
          rx_error  <= ~rx_pin;
        end else if (rx_idx != 4'h0) begin
          rx_data <= {rx_pin, rx_data[7:1]};
        end
      end else if (rx_active) begin
        rx_cnt <= rx_cnt - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  // start, 8 data LSB first, stop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_pin   <= 1'b1;
      tx_busy  <= 1'b0;
      tx_cnt   <= 16'h0000;
      tx_idx   <= 4'h0;
      tx_shift <= 10'h3ff;
    end else if (tx_start && !tx_busy) begin
      tx_busy  <= 1'b1;
      tx_pin   <= 1'b0;
      tx_shift <= {1'b1, 1'b1, tx_data};
      tx_cnt   <= bit_period - 16'h0001;
      tx_idx   <= 4'h0;
    end else if (tx_tick) begin
      tx_cnt <= bit_period - 16'h0001;
      tx_idx <= tx_idx + 4'h1;
      if (tx_is_last) begin
        tx_busy <= 1'b0;
        tx_pin  <= 1'b1;
      end else begin
        tx_pin   <= tx_shift[0];
        tx_shift <= {1'b1, tx_shift[9:1]};
      end
    end else if (tx_busy) begin
      tx_cnt <= tx_cnt - 16'h0001;
    end
  end

endmodule : serial_link

`default_nettype wire

/* File: design/flash_boot_ctrl.sv */
// Flash RAM overlay register, on-board programming mode decode and serial boot loader
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`default_nettype none

module flash_boot_ctrl (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire flash_boot_pkg::reg_req_s   bus_req,
  output var  logic [15:0]                rd_data,
  input  wire logic                       hw_standby,
  input  wire logic                       flash_write_enable_pin,
  input  wire logic                       mode_pin_3,
  input  wire logic                       mode_pin_2,
  input  wire logic                       mode_pin_1,
  input  wire logic                       mode_pin_0,
  input  wire logic [23:0]                cpu_addr,
  output var  logic [23:0]                mapped_addr,
  output var  logic                       overlay_hit,
  output var  logic                       flash_pe_allowed,
  output var  logic                       onboard_prog_state,
  output var  logic                       boot_mode,
  output var  logic                       single_chip_mode,
  output var  logic [1:0]                 pll_mult,
  input  wire logic                       serial_rx,
  output var  logic                       serial_tx,
  output var  flash_boot_pkg::ram_wr_s    ram_wr,
  output var  logic                       branch_valid,
  output var  logic [23:0]                branch_addr
);
  import flash_boot_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0]        flash_overlay_control;
  logic               mode_captured;
  boot_state_e        state;
  boot_state_e        next_state;
  logic [MEAS_W-1:0]  low_cnt;
  logic [15:0]        bit_period;
  logic [15:0]        load_len;
  logic [15:0]        load_idx;
  logic               adjust_done;

  logic               link_tx_busy;
  logic               link_rx_valid;
  logic [7:0]         link_rx_data;
  logic               link_rx_error;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire sel_ovl    = bus_req.addr == OVL_CTRL_OFFSET;
  wire sel_status = bus_req.addr == BOOT_STATUS_OFFSET;
  wire sel_period = bus_req.addr == BIT_PERIOD_OFFSET;
  wire ovl_write  = bus_req.wr & sel_ovl;

  wire emulation_select    = flash_overlay_control[EMU_SEL_BIT];
  wire overlay_area_sel_hi = flash_overlay_control[AREA_HI_BIT];
  wire overlay_area_sel_lo = flash_overlay_control[AREA_LO_BIT];

  boot_status_s status_word;
  assign status_word.zero             = 7'h00;
  assign status_word.flash_pe_allowed = flash_pe_allowed;
  assign status_word.link_error       = state == ST_FAIL;
  assign status_word.load_done        = state == ST_RUN;
  assign status_word.adjust_done      = adjust_done;
  assign status_word.pll_mult         = pll_mult;
  assign status_word.single_chip      = single_chip_mode;
  assign status_word.boot_mode        = boot_mode;
  assign status_word.onboard          = onboard_prog_state;

  // Unmapped offsets read as zero
  wire [15:0] next_rd_data = !bus_req.rd ? 16'h0000 :
                             sel_ovl     ? flash_overlay_control :
                             sel_status  ? status_word :
                             sel_period  ? bit_period : 16'h0000;

  // ----------------------------------------------------------------
  // Overlay decode
  // ----------------------------------------------------------------
  // block select by area bits
  wire in_top_blocks = cpu_addr[23:12] == FLASH_OVL_BASE[23:12];
  wire area_match    = cpu_addr[11:OVL_BLOCK_BITS] == {overlay_area_sel_hi, overlay_area_sel_lo};
  wire next_hit      = emulation_select & in_top_blocks & area_match;
  // same offset inside the overlay RAM
  wire [23:0] next_mapped = next_hit ?
                            {OVL_RAM_BASE[23:OVL_BLOCK_BITS], cpu_addr[OVL_BLOCK_BITS-1:0]} :
                            cpu_addr;
  wire next_pe_allowed = flash_write_enable_pin & ~emulation_select;

  // ----------------------------------------------------------------
  // Mode pin decode
  // ----------------------------------------------------------------
  // pin meanings
  wire [1:0] pin_mult     = {mode_pin_3, mode_pin_2};
  wire       pin_onboard  = flash_write_enable_pin & (pin_mult != PLL_INVALID);
  wire       pin_boot     = ~mode_pin_1;
  wire       pin_single   = mode_pin_0;
  wire       boot_enabled = onboard_prog_state & boot_mode;

  // ----------------------------------------------------------------
  // Boot sequence decode
  // ----------------------------------------------------------------
  wire [MEAS_W+5:0] scaled_low  = low_cnt * DIV9_MUL;
  wire [15:0]       next_period = scaled_low[DIV9_SHIFT+15:DIV9_SHIFT];
  wire              low_full    = &low_cnt;
  wire              link_enable = adjust_done;
  wire              rx_byte     = link_rx_valid;
  wire              last_byte   = load_idx == load_len - 16'h0001;
  wire              receiving   = state == ST_WAIT_ACK || state == ST_LEN_HI ||
                                  state == ST_LEN_LO || state == ST_LOAD;

  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        // only the boot setting starts the loader
        if (mode_captured && boot_enabled) begin
          next_state = ST_WAIT_IDLE;
        end
      end
      ST_WAIT_IDLE: begin
        if (serial_rx) begin
          next_state = ST_MEASURE;
        end
      end
      ST_MEASURE: begin
        // low run ends at the rising edge
        if (serial_rx && low_cnt != '0) begin
          next_state = ST_SEND_END;
        end
      end
      ST_SEND_END: begin
        next_state = ST_WAIT_TX;
      end
      ST_WAIT_TX: begin
        if (!link_tx_busy) begin
          next_state = ST_WAIT_ACK;
        end
      end
      ST_WAIT_ACK: begin
        // trailing sync bytes are skipped, anything else fails
        if (rx_byte && link_rx_data == ACK_BYTE) begin
          next_state = ST_LEN_HI;
        end else if (rx_byte && link_rx_data != SYNC_BYTE) begin
          next_state = ST_FAIL;
        end
      end
      ST_LEN_HI: begin
        if (rx_byte) begin
          next_state = ST_LEN_LO;
        end
      end
      ST_LEN_LO: begin
        if (rx_byte) begin
          next_state = ({load_len[15:8], link_rx_data} == 16'h0000) ? ST_BRANCH : ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (rx_byte && last_byte) begin
          next_state = ST_BRANCH;
        end
      end
      ST_BRANCH: begin
        next_state = ST_RUN;
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      ST_FAIL: begin
        next_state = ST_FAIL;
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
    if (receiving && link_rx_error) begin
      next_state = ST_FAIL;
    end
  end

  // ----------------------------------------------------------------
  // Overlay control register
  // ----------------------------------------------------------------
  // Software standby needs no term: only reset, hardware standby and a register write change it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flash_overlay_control <= OVL_CTRL_RESET;
    end else if (hw_standby) begin
      flash_overlay_control <= OVL_CTRL_RESET;
    end else if (ovl_write) begin
      flash_overlay_control <= bus_req.wdata & OVL_CTRL_RW_MASK;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= 16'h0000;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // ----------------------------------------------------------------
  // Overlay address path
  // ----------------------------------------------------------------
  // Registered so the remap adds one cycle; hence software keeps one access of slack
  // access right after a write may see old mapping
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mapped_addr      <= 24'h000000;
      overlay_hit      <= 1'b0;
      flash_pe_allowed <= 1'b0;
    end else begin
      mapped_addr      <= next_mapped;
      overlay_hit      <= next_hit;
      flash_pe_allowed <= next_pe_allowed;
    end
  end

  // ----------------------------------------------------------------
  // Mode capture
  // ----------------------------------------------------------------
  // Pins are caught on the first edge after reset release, never by the reset itself
  // reset-start latches the programming state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_captured      <= 1'b0;
      onboard_prog_state <= 1'b0;
      boot_mode          <= 1'b0;
      single_chip_mode   <= 1'b0;
      pll_mult           <= PLL_X1;
    end else if (!mode_captured) begin
      mode_captured      <= 1'b1;
      onboard_prog_state <= pin_onboard;
      boot_mode          <= pin_boot;
      single_chip_mode   <= pin_single;
      pll_mult           <= pin_mult;
    end
  end

  // ----------------------------------------------------------------
  // Boot sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // low period of start plus eight zero bits
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt <= '0;
    end else if (state == ST_MEASURE && !serial_rx && !low_full) begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  // bit time is the low run over nine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_period  <= 16'h0000;
      adjust_done <= 1'b0;
    end else if (state == ST_MEASURE && next_state == ST_SEND_END) begin
      bit_period  <= next_period;
      adjust_done <= 1'b1;
    end
  end

  // length then code bytes into transfer RAM
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      load_len <= 16'h0000;
      load_idx <= 16'h0000;
      ram_wr   <= '0;
    end else begin
      ram_wr.valid <= 1'b0;
      if (rx_byte && state == ST_LEN_HI) begin
        load_len[15:8] <= link_rx_data;
      end
      if (rx_byte && state == ST_LEN_LO) begin
        load_len[7:0] <= link_rx_data;
        load_idx      <= 16'h0000;
      end
      if (rx_byte && state == ST_LOAD) begin
        ram_wr.valid <= 1'b1;
        ram_wr.addr  <= TRANSFER_BASE + {8'h00, load_idx};
        ram_wr.data  <= link_rx_data;
        load_idx     <= load_idx + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      branch_valid <= 1'b0;
      branch_addr  <= 24'h000000;
    end else begin
      branch_valid <= state == ST_BRANCH;
      if (state == ST_BRANCH) begin
        branch_addr <= TRANSFER_BASE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial channel
  // ----------------------------------------------------------------
  // one adjustment-end byte
  serial_link u_serial_link (
    .clk        (clk),
    .reset_n    (reset_n),
    .enable     (link_enable),
    .bit_period (bit_period),
    .rx_pin     (serial_rx),
    .tx_start   (state == ST_SEND_END),
    .tx_data    (ADJUST_END_BYTE),
    .tx_pin     (serial_tx),
    .tx_busy    (link_tx_busy),
    .rx_valid   (link_rx_valid),
    .rx_data    (link_rx_data),
    .rx_error   (link_rx_error)
  );

endmodule : flash_boot_ctrl

`default_nettype wire

/* File: bench/flash_boot_ctrl_props.sv */
// Port checker for the flash overlay and boot control block
`default_nettype none

module flash_boot_ctrl_props (
  input wire logic                     clk,
  input wire logic                     reset_n,
  input wire flash_boot_pkg::reg_req_s bus_req,
  input wire logic [15:0]              rd_data,
  input wire logic                     flash_write_enable_pin,
  input wire logic [23:0]              cpu_addr,
  input wire logic [23:0]              mapped_addr,
  input wire logic                     overlay_hit,
  input wire logic                     flash_pe_allowed,
  input wire logic                     onboard_prog_state,
  input wire logic                     boot_mode,
  input wire logic [1:0]               pll_mult,
  input wire flash_boot_pkg::ram_wr_s  ram_wr,
  input wire logic                     branch_valid,
  input wire logic [23:0]              branch_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  import flash_boot_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire [9:0]  cpu_low = cpu_addr[9:0];
  wire [11:0] cpu_hi  = cpu_addr[23:12];
  // ----------------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------------
  sequence s_ctrl_read;
    bus_req.rd && bus_req.addr == OVL_CTRL_OFFSET;
  endsequence
  // First edge after reset sees stale history, so it is skipped
  sequence s_hit;
    $past(reset_n) && overlay_hit;
  endsequence
  a_ctrl_reserved: assert property (s_ctrl_read |=> rd_data[15:3] == 13'h0000)
    else $error("reserved control bits read nonzero");
  a_hit_offset: assert property (s_hit |-> mapped_addr == {OVL_RAM_BASE[23:10], $past(cpu_low)})
    else $error("redirected address wrong");
  a_hit_block: assert property (s_hit |-> $past(cpu_hi) == 12'h01f)
    else $error("redirect outside overlay blocks");
  a_miss_pass: assert property ($past(reset_n) && !overlay_hit |-> mapped_addr == $past(cpu_addr))
    else $error("address changed without redirect");
  a_hit_protect: assert property (overlay_hit |-> !flash_pe_allowed)
    else $error("program allowed while overlay active");
  a_fwe_protect: assert property ($past(reset_n) && !$past(flash_write_enable_pin) |-> !flash_pe_allowed)
    else $error("program allowed with write enable low");
  a_mode_valid: assert property (onboard_prog_state |-> pll_mult != PLL_INVALID)
    else $error("onboard state with invalid multiplier");
  a_load_target: assert property (ram_wr.valid |-> ram_wr.addr[23:12] == TRANSFER_BASE[23:12]
    && boot_mode && onboard_prog_state)
    else $error("code byte stored outside boot load");
  a_branch_once: assert property (branch_valid |-> branch_addr == TRANSFER_BASE ##1 (!branch_valid) [*8])
    else $error("branch pulse or target wrong");
endmodule : flash_boot_ctrl_props

`default_nettype wire

/* File: bench/serial_host.sv */
// Host model of the boot serial link
`default_nettype none

module serial_host #(
  parameter int BIT = 45
) (
  input  wire logic       clk,
  input  wire logic       serial_tx,
  input  wire logic       go,
  output var  logic       serial_rx,
  output var  logic [7:0] got,
  output var  logic       got_stop,
  output var  int         falls
);
  timeunit 1ns;
  timeprecision 1ps;
  // scaled bit time, real rates would make the run far too long
  // One late sync byte first, as a host still repeating 00 would send
  logic [7:0] code [6] = '{8'h00, 8'h55, 8'h00, 8'h02, 8'ha5, 8'h3c};
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold
  task automatic send(input logic [7:0] b);
    serial_rx <= 1'b0;
    hold(BIT);
    for (int i = 0; i < 8; i++) begin
      serial_rx <= b[i];
      hold(BIT);
    end
    serial_rx <= 1'b1;
    hold(BIT);
  endtask : send
  always @(negedge serial_tx) falls <= falls + 1;
  initial begin
    serial_rx = 1'b1;
    falls = 0;
    got = 8'h00;
    got_stop = 1'b0;
    wait (go);
    @(posedge clk);
    // sync byte low for nine bits
    serial_rx <= 1'b0;
    hold(9 * BIT);
    serial_rx <= 1'b1;
    wait (serial_tx === 1'b0);
    hold(BIT / 2);
    for (int i = 0; i < 8; i++) begin
      hold(BIT);
      got[i] <= serial_tx;
    end
    hold(BIT);
    got_stop <= serial_tx;
    hold(BIT);
    foreach (code[i]) send(code[i]);
  end
endmodule : serial_host

`default_nettype wire

/* File: bench/tb_flash_boot_ctrl.sv */
// Testbench for the flash overlay and boot control block
`default_nettype none

module tb_flash_boot_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_boot_pkg::*;
  logic        clk, reset_n, hw_standby, flash_write_enable_pin;
  logic        mode_pin_3, mode_pin_2, mode_pin_1, mode_pin_0;
  reg_req_s    bus_req;
  logic [15:0] rd_data;
  logic [23:0] cpu_addr, mapped_addr, branch_addr;
  logic        overlay_hit, flash_pe_allowed, onboard_prog_state, boot_mode, single_chip_mode;
  logic [1:0]  pll_mult;
  logic        serial_rx, serial_tx, branch_valid, go, got_stop, br_seen;
  ram_wr_s     ram_wr;
  ram_wr_s     loads[$];
  logic [7:0]  got;
  int          falls, failures, total_checks;
  flash_boot_ctrl i_flash_boot_ctrl (.clk, .reset_n, .bus_req, .rd_data, .hw_standby, .flash_write_enable_pin,
    .mode_pin_3, .mode_pin_2, .mode_pin_1, .mode_pin_0, .cpu_addr, .mapped_addr, .overlay_hit,
    .flash_pe_allowed, .onboard_prog_state, .boot_mode, .single_chip_mode, .pll_mult, .serial_rx,
    .serial_tx, .ram_wr, .branch_valid, .branch_addr);
  serial_host i_serial_host (.clk, .serial_tx, .go, .serial_rx, .got, .got_stop, .falls);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #200000;
    failures++;
    end_sim();
  end
  always @(posedge clk) begin
    if (ram_wr.valid === 1'b1) loads.push_back(ram_wr);
    if (branch_valid === 1'b1) br_seen <= 1'b1;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask : wr
  task automatic rchk(input string what, input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1 chk(what, e, rd_data);
  endtask : rchk
  task automatic at(input logic [23:0] a, input logic h, input logic [23:0] m);
    @(posedge clk);
    cpu_addr <= a;
    @(posedge clk);
    #1 chk("hit", h, overlay_hit);
    chk("mapped", m, mapped_addr);
  endtask : at
  task automatic restart(input logic [3:0] md);
    @(posedge clk);
    reset_n <= 1'b0;
    {mode_pin_3, mode_pin_2, mode_pin_1, mode_pin_0} <= md;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : restart
  task automatic t_modes();
    logic [3:0] md;
    for (int i = 0; i < 16; i++) begin
      md = i[3:0];
      restart(md);
      rchk("status", BOOT_STATUS_OFFSET, {8'h01, 3'h0, md[3:2], md[0], ~md[1], md[3:2] != 2'h3});
      rchk("ctrl reset", OVL_CTRL_OFFSET, 16'h0000);
      chk("pins", {md[3:2], md[0], ~md[1]}, {pll_mult, single_chip_mode, boot_mode});
    end
    flash_write_enable_pin <= 1'b0;
    restart(4'h3);
    rchk("status fwe low", BOOT_STATUS_OFFSET, 16'h0004);
    flash_write_enable_pin <= 1'b1;
  endtask : t_modes
  task automatic t_regs();
    wr(OVL_CTRL_OFFSET, 16'hffff);
    rchk("ctrl rw bits", OVL_CTRL_OFFSET, 16'h0007);
    wr(4'hf, 16'h1234);
    rchk("unmapped", 4'hf, 16'h0000);
    rchk("ctrl kept", OVL_CTRL_OFFSET, 16'h0007);
    @(posedge clk);
    hw_standby <= 1'b1;
    @(posedge clk);
    hw_standby <= 1'b0;
    rchk("ctrl standby", OVL_CTRL_OFFSET, 16'h0000);
  endtask : t_regs
  task automatic t_overlay();
    for (int k = 0; k < 4; k++) begin
      wr(OVL_CTRL_OFFSET, 16'h0004 | k[15:0]);
      @(posedge clk);
      at({12'h01f, k[1:0], 10'h3ff}, 1'b1, 24'hffebff);
      chk("pe off", 1'b0, flash_pe_allowed);
      at({12'h01f, k[1:0] + 2'h1, 10'h000}, 1'b0, {12'h01f, k[1:0] + 2'h1, 10'h000});
    end
    wr(OVL_CTRL_OFFSET, 16'h0003);
    @(posedge clk);
    at(24'h01fc10, 1'b0, 24'h01fc10);
    chk("pe on", 1'b1, flash_pe_allowed);
    at(24'hffe810, 1'b0, 24'hffe810);
  endtask : t_overlay
  task automatic t_boot();
    restart(4'h1);
    go <= 1'b1;
    for (int n = 0; n < 20000 && !br_seen; n++) @(posedge clk);
    repeat (10) @(posedge clk);
    chk("branch seen", 1'b1, br_seen);
    chk("branch addr", 24'hfff000, branch_addr);
    chk("end byte", 8'h00, got);
    chk("end stop", 1'b1, got_stop);
    chk("end count", 1, 32'(falls));
    chk("loads", 2, loads.size());
    chk("load 0", {24'hfff000, 8'ha5}, {loads[0].addr, loads[0].data});
    chk("load 1", {24'hfff001, 8'h3c}, {loads[1].addr, loads[1].data});
    rchk("status boot", BOOT_STATUS_OFFSET, 16'h0167);
  endtask : t_boot
  initial begin
    bus_req = '0;
    reset_n = 1'b0;
    hw_standby = 1'b0;
    flash_write_enable_pin = 1'b1;
    {mode_pin_3, mode_pin_2, mode_pin_1, mode_pin_0} = 4'h3;
    cpu_addr = 24'h000000;
    go = 1'b0;
    br_seen = 1'b0;
    failures = 0;
    total_checks = 0;
    t_modes();
    restart(4'h3);
    t_regs();
    t_overlay();
    t_boot();
    end_sim();
  end
endmodule : tb_flash_boot_ctrl

bind flash_boot_ctrl flash_boot_ctrl_props i_flash_boot_ctrl_props (.clk, .reset_n, .bus_req, .rd_data,
  .flash_write_enable_pin, .cpu_addr, .mapped_addr, .overlay_hit, .flash_pe_allowed, .onboard_prog_state,
  .boot_mode, .pll_mult, .ram_wr, .branch_valid, .branch_addr);

`default_nettype wire
